// ===== hw/ftms_top.v
// frame trigger edge handling and master/slave line/frame sync
// assumes: pins arrive asynchronously; config ports are core-clock
// levels; the link pins are resolved outside from the enables
//
// Contract
// - start-only, rising selected: frame starts on low-to-high trigger.
// - start-only, falling selected: frame starts on high-to-low trigger.
// - start/stop, rising start: start on rise, stop on next fall.
// - start/stop, falling start: start on fall, stop on next rise.
// - role values: from setting, master, slave, auto by select input.
// - master forwards trigger timing to slaves over the sync link.
// - all devices produce line and frame timing identical to master.
// - frame length comes from master; slave ignores own length.
// - each device keeps its own image offset along transport.
// - each device keeps own white-reference position and size.
// - commanded master or slave role needs no select input.
// - role value stored per configuration set; set switch may change it.
// - trigger sampled each line clock rise; debounce met before accept.
// - debounce: 60 lines, 4 clocks, peak hold, or 4 lines.
// - auto mode: select input high means slave, low means master.
`timescale 1ns/1ps
`default_nettype none
`include "ftms_regs.vh"

module ftms_top (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_line_clk,
  input wire i_trig,
  input wire [1:0] i_trig_mode,
  input wire i_edge_rising,
  input wire [1:0] i_debounce_sel,
  input wire [1:0] i_cfg_set,
  input wire i_role_wr,
  input wire [1:0] i_role_wr_set,
  input wire [1:0] i_role_wr_val,
  input wire i_setting_is_master,
  input wire i_role_select_in_n,
  input wire i_master_free_run,
  input wire [15:0] i_frame_lines,
  input wire [15:0] i_y_offset,
  input wire [15:0] i_wref_x,
  input wire [15:0] i_wref_y,
  input wire [15:0] i_wref_size,
  input wire i_sync_link_line,
  output reg o_sync_link_line,
  output reg o_sync_link_line_oe,
  input wire i_sync_link_frame,
  output reg o_sync_link_frame,
  output reg o_sync_link_frame_oe,
  output reg o_is_master,
  output reg o_line_pulse,
  output reg o_frame_active,
  output reg o_frame_start,
  output reg o_frame_stop,
  output reg o_image_active,
  output reg o_wref_active,
  output reg [15:0] o_wref_x,
  output reg o_trig_level
);

  localparam ST_IDLE = 1'b0;
  localparam ST_FRAME = 1'b1;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire line_clk_s;
  wire trig_s;
  wire sel_n_s;
  wire link_line_s;
  wire link_frame_s;

  ftms_pin_sync u_sync_line (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_line_clk),
    .o_level(line_clk_s)
  );

  ftms_pin_sync u_sync_trig (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_trig),
    .o_level(trig_s)
  );

  ftms_pin_sync u_sync_sel (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_role_select_in_n),
    .o_level(sel_n_s)
  );

  ftms_pin_sync u_sync_link_line (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_sync_link_line),
    .o_level(link_line_s)
  );

  ftms_pin_sync u_sync_link_frame (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_sync_link_frame),
    .o_level(link_frame_s)
  );

  // ------------------------------------------------------------
  // role table, one entry per configuration set
  // ------------------------------------------------------------
  reg [1:0] role_tbl_q [0:`FTMS_NUM_SETS-1];
  reg is_master_d;
  integer k;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (k = 0; k < `FTMS_NUM_SETS; k = k + 1) begin
        role_tbl_q[k] <= `FTMS_ROLE_SETTING;
      end
    end else if (i_role_wr) begin
      role_tbl_q[i_role_wr_set] <= i_role_wr_val;
    end
  end

  always @* begin
    case (role_tbl_q[i_cfg_set])
      `FTMS_ROLE_SETTING: is_master_d = i_setting_is_master;
      `FTMS_ROLE_MASTER: is_master_d = 1'b1;
      `FTMS_ROLE_SLAVE: is_master_d = 1'b0;
      default: is_master_d = ~sel_n_s;
    endcase
  end

  // ------------------------------------------------------------
  // line timing: own line clock as master, link line as slave
  // ------------------------------------------------------------
  reg line_prev_q;
  wire line_lvl;
  wire line_edge;

  assign line_lvl = o_is_master ? line_clk_s : link_line_s;
  assign line_edge = line_lvl & ~line_prev_q;

  // ------------------------------------------------------------
  // trigger debounce, sampled on each line clock rise
  // ------------------------------------------------------------
  reg acc_q;
  reg acc_d;
  reg [5:0] ln_cnt_q;
  reg [5:0] ln_cnt_d;
  reg [5:0] ln_need;
  reg [2:0] ck_cnt_q;
  reg ck_lvl_q;
  reg peak_q;
  wire peak_d;

  // four-clock stability filter on the core clock
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ck_cnt_q <= `FTMS_CK_CNT_ZERO;
      ck_lvl_q <= 1'b0;
    end else if (trig_s == ck_lvl_q) begin
      ck_cnt_q <= `FTMS_CK_CNT_ZERO;
    end else if (ck_cnt_q + `FTMS_CK_CNT_ONE >= `FTMS_CLK_PULSES_N) begin
      ck_cnt_q <= `FTMS_CK_CNT_ZERO;
      ck_lvl_q <= trig_s;
    end else begin
      ck_cnt_q <= ck_cnt_q + `FTMS_CK_CNT_ONE;
    end
  end

  // peak holder: any change between samples is kept; new event wins
  assign peak_d = (line_edge ? 1'b0 : peak_q) | (trig_s != acc_d);

  always @* begin
    acc_d = acc_q;
    ln_cnt_d = ln_cnt_q;
    ln_need = (i_debounce_sel == `FTMS_DB_LONG_LINES) ?
              `FTMS_LONG_LINES_N : `FTMS_SHORT_LINES_N;
    if (line_edge) begin
      if (i_debounce_sel == `FTMS_DB_CLK_PULSES) begin
        acc_d = ck_lvl_q;
        ln_cnt_d = `FTMS_LN_CNT_ZERO;
      end else if (i_debounce_sel == `FTMS_DB_PEAK_HOLD) begin
        if (peak_q | (trig_s != acc_q)) begin
          acc_d = ~acc_q;
        end
        ln_cnt_d = `FTMS_LN_CNT_ZERO;
      end else if (trig_s == acc_q) begin
        ln_cnt_d = `FTMS_LN_CNT_ZERO;
      end else if (ln_cnt_q + `FTMS_LN_CNT_ONE >= ln_need) begin
        acc_d = trig_s;
        ln_cnt_d = `FTMS_LN_CNT_ZERO;
      end else begin
        ln_cnt_d = ln_cnt_q + `FTMS_LN_CNT_ONE;
      end
    end
  end

  // ------------------------------------------------------------
  // edge events from the accepted level
  // ------------------------------------------------------------
  wire trig_rise;
  wire trig_fall;
  wire start_ev;
  wire stop_ev;

  assign trig_rise = acc_d & ~acc_q;
  assign trig_fall = ~acc_d & acc_q;
  assign start_ev = (i_trig_mode == `FTMS_TRIG_START ||
                     i_trig_mode == `FTMS_TRIG_START_STOP) &&
                    (i_edge_rising ? trig_rise : trig_fall);
  assign stop_ev = (i_trig_mode == `FTMS_TRIG_START_STOP) &&
                   (i_edge_rising ? trig_fall : trig_rise);

  // ------------------------------------------------------------
  // master frame state machine
  // ------------------------------------------------------------
  reg state_q;
  reg state_d;
  reg [15:0] lcnt_q;
  reg [15:0] lcnt_d;
  wire len_done;

  // frame length ends a frame only on the master; lines are counted in both roles
  assign len_done = line_edge &&
                    (lcnt_q + `FTMS_CNT_ONE >= i_frame_lines);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (o_is_master && start_ev) begin
          state_d = ST_FRAME;
        end
      end
      default: begin
        if (!o_is_master) begin
          state_d = ST_IDLE;
        end else if (i_trig_mode == `FTMS_TRIG_START_STOP) begin
          if (stop_ev) begin
            state_d = ST_IDLE;
          end
        end else if (i_trig_mode != `FTMS_TRIG_START || len_done) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // frame as seen by this device
  // ------------------------------------------------------------
  reg frame_d;

  always @* begin
    if (o_is_master) begin
      frame_d = (state_d == ST_FRAME);
    end else if (i_master_free_run) begin
      frame_d = 1'b0;
    end else begin
      frame_d = link_frame_s;
    end
  end

  always @* begin
    lcnt_d = lcnt_q;
    if (frame_d && !o_frame_active) begin
      lcnt_d = `FTMS_CNT_ZERO;
    end else if (o_frame_active && line_edge) begin
      lcnt_d = lcnt_q + `FTMS_CNT_ONE;
    end
  end

  wire free_run;
  assign free_run = o_is_master ? (i_trig_mode == `FTMS_TRIG_FREE) :
                    i_master_free_run;

  // ------------------------------------------------------------
  // registers and outputs
  // ------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_is_master <= 1'b0;
      line_prev_q <= 1'b0;
      acc_q <= 1'b0;
      ln_cnt_q <= `FTMS_LN_CNT_ZERO;
      peak_q <= 1'b0;
      state_q <= ST_IDLE;
      lcnt_q <= `FTMS_CNT_ZERO;
      o_sync_link_line <= 1'b0;
      o_sync_link_line_oe <= 1'b0;
      o_sync_link_frame <= 1'b0;
      o_sync_link_frame_oe <= 1'b0;
      o_line_pulse <= 1'b0;
      o_frame_active <= 1'b0;
      o_frame_start <= 1'b0;
      o_frame_stop <= 1'b0;
      o_image_active <= 1'b0;
      o_wref_active <= 1'b0;
      o_wref_x <= `FTMS_CNT_ZERO;
      o_trig_level <= 1'b0;
    end else begin
      o_is_master <= is_master_d;
      line_prev_q <= line_lvl;
      acc_q <= acc_d;
      ln_cnt_q <= ln_cnt_d;
      peak_q <= peak_d;
      state_q <= state_d;
      lcnt_q <= lcnt_d;
      o_sync_link_line <= line_clk_s;
      o_sync_link_line_oe <= is_master_d;
      o_sync_link_frame <= o_is_master && (state_d == ST_FRAME);
      o_sync_link_frame_oe <= is_master_d;
      o_line_pulse <= line_edge;
      o_frame_active <= frame_d;
      o_frame_start <= frame_d & ~o_frame_active;
      o_frame_stop <= ~frame_d & o_frame_active;
      o_image_active <= free_run ||
                        (frame_d && lcnt_d >= i_y_offset);
      o_wref_active <= frame_d && lcnt_d >= i_wref_y &&
                       (lcnt_d - i_wref_y) < i_wref_size;
      o_wref_x <= i_wref_x;
      o_trig_level <= acc_d;
    end
  end

endmodule // ftms_top

`default_nettype wire

// ===== common/ftms_regs.vh
// constants of the frame trigger and master/slave sync block
// assumes: included by bare name from the design files
`ifndef FTMS_REGS_VH
`define FTMS_REGS_VH

// ------------------------------------------------------------
// sync role settings
// ------------------------------------------------------------
`define FTMS_ROLE_SETTING 2'h0
`define FTMS_ROLE_MASTER 2'h1
`define FTMS_ROLE_SLAVE 2'h2
`define FTMS_ROLE_AUTO 2'h3
`define FTMS_NUM_SETS 4

// ------------------------------------------------------------
// debounce options
// ------------------------------------------------------------
`define FTMS_DB_LONG_LINES 2'h0
`define FTMS_DB_CLK_PULSES 2'h1
`define FTMS_DB_PEAK_HOLD 2'h2
`define FTMS_DB_SHORT_LINES 2'h3
`define FTMS_LONG_LINES_N 6'h3C
`define FTMS_SHORT_LINES_N 6'h04
`define FTMS_LN_CNT_ZERO 6'h00
`define FTMS_LN_CNT_ONE 6'h01
`define FTMS_CLK_PULSES_N 3'h4
`define FTMS_CK_CNT_ZERO 3'h0
`define FTMS_CK_CNT_ONE 3'h1

// ------------------------------------------------------------
// triggered frame scan modes
// ------------------------------------------------------------
`define FTMS_TRIG_FREE 2'h0
`define FTMS_TRIG_START 2'h1
`define FTMS_TRIG_START_STOP 2'h2

// ------------------------------------------------------------
// line counters
// ------------------------------------------------------------
`define FTMS_CNT_ZERO 16'h0000
`define FTMS_CNT_ONE 16'h0001

`endif

// ===== hw/ftms_pin_sync.v
// three-stage synchroniser for one pin-level input
// assumes: i_pin is asynchronous to i_core_clk
`timescale 1ns/1ps
`default_nettype none

module ftms_pin_sync (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_pin,
  output reg o_level
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ------------------------------------------------------------
  // level changes only once stage two and three agree
  // ------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end

endmodule // ftms_pin_sync

`default_nettype wire

// ===== bench/ftms_chk.sv
// port checker for ftms_top
// assumes: bound onto every ftms_top instance
`timescale 1ns/1ps
`default_nettype none

module ftms_chk (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_wref_x,
  input wire logic o_sync_link_line_oe,
  input wire logic o_sync_link_frame,
  input wire logic o_sync_link_frame_oe,
  input wire logic o_is_master,
  input wire logic o_line_pulse,
  input wire logic o_frame_active,
  input wire logic o_frame_start,
  input wire logic o_frame_stop,
  input wire logic [15:0] o_wref_x
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ----
  // assertions
  // ----
  start_rise_a: assert property (o_frame_start |-> $rose(o_frame_active))
    else $error("start without frame rise");
  stop_fall_a: assert property (o_frame_stop |-> $fell(o_frame_active))
    else $error("stop without frame fall");
  start_once_a: assert property (o_frame_start |=> !o_frame_start && !o_frame_stop)
    else $error("second event after start");
  start_line_a: assert property (o_is_master && o_frame_start |-> o_line_pulse)
    else $error("start off a line");
  link_frame_a: assert property (o_is_master && o_frame_start
    |-> o_sync_link_frame && o_sync_link_frame_oe) else $error("frame not sent");
  master_drive_a: assert property (o_is_master[*3] |-> o_sync_link_line_oe)
    else $error("master not driving link");
  slave_quiet_a: assert property (!o_is_master[*3]
    |-> !o_sync_link_line_oe && !o_sync_link_frame_oe) else $error("slave drives");
  wref_copy_a: assert property ((!i_rst && $stable(i_wref_x))[*3]
    |-> o_wref_x == i_wref_x) else $error("wref x lost");
  // ----
  // covers
  // ----
  cover property (o_frame_start);
  cover property (o_frame_stop);
  cover property ($fell(o_is_master));
endmodule // ftms_chk

bind ftms_top ftms_chk u_ftms_chk (.i_core_clk, .i_rst, .i_wref_x,
  .o_sync_link_line_oe, .o_sync_link_frame, .o_sync_link_frame_oe,
  .o_is_master, .o_line_pulse, .o_frame_active, .o_frame_start,
  .o_frame_stop, .o_wref_x);
`default_nettype wire

// ===== bench/ftms_partner.sv
// line clock, trigger source and external sync master
// assumes: testbench commands trigger and link frame levels
`timescale 1ns/1ps
`default_nettype none

module ftms_partner (
  input wire logic i_trig_cmd,
  input wire logic i_frame_cmd,
  input wire logic i_dut_line,
  input wire logic i_dut_line_oe,
  input wire logic i_dut_frame,
  input wire logic i_dut_frame_oe,
  output logic o_line_clk,
  output logic o_trig,
  output logic o_link_line,
  output logic o_link_frame
);
  // line period is 20 core cycles, edges on core clock falling edges
  initial begin
    o_line_clk = 1'b0;
    forever #500 o_line_clk = ~o_line_clk;
  end
  // trigger goes to the device in either role, skewed off the core clock
  assign #7 o_trig = i_trig_cmd;
  // one-to-one link: device drives when master, else this model
  assign o_link_line = i_dut_line_oe ? i_dut_line : o_line_clk;
  assign o_link_frame = i_dut_frame_oe ? i_dut_frame : i_frame_cmd;
endmodule // ftms_partner
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for ftms_top
// assumes: ftms_chk bound, ftms_partner as far side
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk, rst, trig_cmd, frame_cmd, edge_r, role_wr, set_m, sel_n;
  logic [1:0] mode, db, cfg, wr_set, wr_val;
  logic [15:0] yoff;
  logic mfr;
  int n_fail, n_tests, cyc_cnt;
  wire line_clk, trig, link_line, link_frame, d_line, d_line_oe;
  wire d_frame, d_frame_oe, is_master, line_pulse, f_act, f_start;
  wire f_stop, img_act, wref_act, trig_lvl;
  wire [15:0] wref_x;

  ftms_top u_ftms_top (.i_core_clk(clk), .i_rst(rst),
    .i_line_clk(line_clk), .i_trig(trig), .i_trig_mode(mode),
    .i_edge_rising(edge_r), .i_debounce_sel(db), .i_cfg_set(cfg),
    .i_role_wr(role_wr), .i_role_wr_set(wr_set), .i_role_wr_val(wr_val),
    .i_setting_is_master(set_m), .i_role_select_in_n(sel_n),
    .i_master_free_run(mfr), .i_frame_lines(16'h0003),
    .i_y_offset(yoff), .i_wref_x(16'h0123), .i_wref_y(16'h0005),
    .i_wref_size(16'h0002), .i_sync_link_line(link_line),
    .o_sync_link_line(d_line), .o_sync_link_line_oe(d_line_oe),
    .i_sync_link_frame(link_frame), .o_sync_link_frame(d_frame),
    .o_sync_link_frame_oe(d_frame_oe), .o_is_master(is_master),
    .o_line_pulse(line_pulse), .o_frame_active(f_act),
    .o_frame_start(f_start), .o_frame_stop(f_stop),
    .o_image_active(img_act), .o_wref_active(wref_act), .o_wref_x(wref_x),
    .o_trig_level(trig_lvl));
  ftms_partner u_ftms_partner (.i_trig_cmd(trig_cmd),
    .i_frame_cmd(frame_cmd), .i_dut_line(d_line),
    .i_dut_line_oe(d_line_oe), .i_dut_frame(d_frame),
    .i_dut_frame_oe(d_frame_oe), .o_line_clk(line_clk), .o_trig(trig),
    .o_link_line(link_line), .o_link_frame(link_frame));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  task automatic finish_test();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // cycles until a start or stop pulse, lim if none
  task automatic wait_ev(input logic stop, input int lim, output int n);
    n = 0;
    while (n < lim && (stop ? f_stop : f_start) !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_roles();
    logic [4:0] tab [6] = '{5'h07, 5'h00, 5'h0B, 5'h14, 5'h1E, 5'h19};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      role_wr <= 1'b1;
      wr_set <= i[1:0];
      wr_val <= i[1:0];
    end
    @(posedge clk) role_wr <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) {cfg, set_m, sel_n} <= tab[i][4:1];
      cyc(10);
      #1 chk(is_master, tab[i][0]);
    end
  endtask
  task automatic t_lines();
    int n, m;
    logic p;
    n = 0;
    m = 0;
    p = link_line;
    repeat (200) begin
      @(posedge clk);
      #1 n += line_pulse;
      m += (link_line && !p);
      p = link_line;
    end
    chk(n, 10);
    chk(m, 10);
  endtask
  task automatic t_start(input logic ss, input logic rise);
    int n;
    @(posedge clk);
    mode <= ss ? 2'h2 : 2'h1;
    edge_r <= rise;
    db <= 2'h2;
    trig_cmd <= ~rise;
    cyc(200);
    trig_cmd <= rise;
    wait_ev(0, 80, n);
    chk(n < 80, 1);
    chk(link_frame, 1);
    chk(trig_lvl, rise);
    wait_ev(1, ss ? 160 : 100, n);
    chk(n > 30 && n < 100, !ss);
    if (ss) begin
      chk(f_act, 1);
      @(posedge clk) trig_cmd <= ~rise;
      wait_ev(1, 80, n);
      chk(n < 80, 1);
    end
  endtask
  task automatic t_db(input logic [1:0] sel, input int g, input int lo,
      input int hi);
    int n;
    @(posedge clk);
    mode <= 2'h1;
    edge_r <= 1'b1;
    db <= 2'h2;
    trig_cmd <= 1'b0;
    cyc(200);
    db <= sel;
    trig_cmd <= 1'b1;
    cyc(g);
    trig_cmd <= 1'b0;
    wait_ev(0, 200, n);
    chk(n < 200, sel == 2'h2);
    cyc(100);
    trig_cmd <= 1'b1;
    wait_ev(0, 1400, n);
    chk(n >= lo && n < hi, 1);
  endtask
  task automatic t_slave();
    int n, w;
    @(posedge clk);
    cfg <= 2'h2;
    mode <= 2'h1;
    yoff <= 16'h0002;
    cyc(10);
    #1 chk(d_frame_oe, 0);
    @(posedge clk) frame_cmd <= 1'b1;
    wait_ev(0, 80, n);
    chk(n < 80, 1);
    chk(img_act, 0);
    w = 0;
    repeat (200) begin
      @(posedge clk);
      #1 w += wref_act;
    end
    chk(w, 40);
    chk(img_act, 1);
    chk(f_act, 1);
    chk(wref_x, 16'h0123);
    @(posedge clk) frame_cmd <= 1'b0;
    wait_ev(1, 80, n);
    chk(n < 80, 1);
    // free-running master: link frame ignored, image always on
    @(posedge clk) begin
      mfr <= 1'b1;
      frame_cmd <= 1'b1;
    end
    cyc(10);
    #1 chk(f_act, 0);
    chk(img_act, 1);
  endtask
  // ----
  // main sequence and hang guard
  // ----
  initial begin
    {rst, trig_cmd, frame_cmd, edge_r, role_wr, set_m, sel_n} = 7'h41;
    {mode, db, cfg, wr_set, wr_val} = 10'h000;
    set_m = 1'b1;
    yoff = 16'h0000;
    mfr = 1'b0;
    n_fail = 0;
    n_tests = 0;
    cyc_cnt = 0;
    cyc(3);
    rst <= 1'b0;
    t_roles();
    t_lines();
    t_start(0, 1);
    t_start(0, 0);
    t_start(1, 1);
    t_start(1, 0);
    t_db(2'h2, 3, 0, 60);
    t_db(2'h1, 2, 0, 60);
    t_db(2'h3, 40, 50, 120);
    t_db(2'h0, 800, 1150, 1260);
    t_slave();
    finish_test();
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      finish_test();
    end
  end
endmodule // testbench
`default_nettype wire
